// File: src/arp_pkg.sv
// constants, field layouts and carrier types of the instruction read port
// assumes an axi-style interconnect on the far side, one system clock
//
// Behaviour
// - burst type is only incrementing 01 or wrapping 10, never fixed.
// - burst length field holds beats minus one, so 1 to 16 beats.
// - every read carries lock type 00, normal access only.
// - size code 000..011 gives 8, 16, 32 or 64 bits per beat.
// - sideband bits 4 to 1 carry the inner memory attribute code.
// - sideband bit 0 is high when the location is shareable.
// - a 4-bit cache type goes out with every read request.
// - bus inputs are sampled only when bus enable is high; valid and address fields load on any clock that takes a request.
package arp_pkg;

    // ------------------------------------------------------------
    // field widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 32;
    localparam int DATA_W = 64;
    localparam int ID_W = 6;
    localparam int LEN_W = 4;
    localparam int USER_W = 5;
    localparam int FIFO_DEPTH = 4;

    // ------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------
    localparam logic [1:0] BURST_INCR = 2'h1;
    localparam logic [1:0] BURST_WRAP = 2'h2;
    localparam logic [1:0] LOCK_NORMAL = 2'h0;
    localparam logic [2:0] SIZE_8 = 3'h0;
    localparam logic [2:0] SIZE_16 = 3'h1;
    localparam logic [2:0] SIZE_32 = 3'h2;
    localparam logic [2:0] SIZE_64 = 3'h3;
    localparam logic [3:0] INNER_SO = 4'h0;
    localparam logic [3:0] INNER_DEV = 4'h1;
    localparam logic [3:0] INNER_NC = 4'h3;
    localparam logic [3:0] INNER_WT = 4'h6;
    localparam logic [3:0] INNER_WB_NA = 4'h7;
    localparam logic [3:0] INNER_WB_WA = 4'hF;
    localparam int USER_INNER_LSB = 1;
    localparam int USER_SHARED_BIT = 0;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
    localparam logic [LEN_W-1:0] LEN_RST = 4'h0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [ID_W-1:0] id;
        logic [LEN_W-1:0] len;
        logic [2:0] size;
        logic wrap;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [3:0] inner;
        logic shared;
    } arp_req_type;

    typedef struct packed {
        logic [1:0] burst;
        logic [1:0] lock;
        logic [1:0] size;
        logic [LEN_W-1:0] len;
        logic [3:0] cache;
        logic [2:0] prot;
        logic [USER_W-1:0] user;
        logic [ID_W-1:0] id;
        logic [ADDR_W-1:0] addr;
    } arp_ar_type;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic [1:0] resp;
        logic [ID_W-1:0] id;
        logic last;
    } arp_beat_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_ADDR = 2'h1,
        ST_DATA = 2'h3
    } arp_state_type;

    // size code fits the two-bit printed field; codes above 011 are clamped to 011
    function automatic logic [1:0] size_field(input logic [2:0] code);
        return (code > SIZE_64) ? SIZE_64[1:0] : code[1:0];
    endfunction

    function automatic logic [USER_W-1:0] user_field(input logic [3:0] inner,
                                                     input logic shared);
        return {inner, shared};
    endfunction

endpackage

// File: src/arp_fifo.sv
// small valid/ready fifo, width and depth as parameters
// assumes one clock and an asynchronous active high reset
`timescale 1ns/1ns
module arp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    // fill side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // drain side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_q;
    logic [PW-1:0] rd_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_q != (PW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_q];

    always_ff @(posedge clock_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end
endmodule // arp_fifo

// File: src/arp_read_port.sv
// instruction-fetch read master port: address channel and data channel
// assumes the interconnect runs at the rate given by bus_clock_enable_i
// and drives its inputs from logic on clock_i
`timescale 1ns/1ns
module arp_read_port
    import arp_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    // clock and reset
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic bus_clock_enable_i,
    // fetch request from the core
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire arp_req_type req_i,
    // fetch data to the core
    output logic beat_valid_o,
    input wire logic beat_ready_i,
    output arp_beat_type beat_o,
    output logic busy_o,
    output logic [1:0] state_o,
    // read address channel
    output logic read_addr_valid_o,
    input wire logic read_addr_ready_i,
    output logic [ADDR_W-1:0] read_addr_o,
    output logic [ID_W-1:0] read_id_o,
    output logic [1:0] read_burst_type_o,
    output logic [LEN_W-1:0] read_burst_length_o,
    output logic [1:0] read_lock_type_o,
    output logic [1:0] read_transfer_size_o,
    output logic [3:0] read_cache_type_o,
    output logic [2:0] read_prot_o,
    output logic [USER_W-1:0] read_attr_sideband_o,
    // read data channel
    input wire logic read_data_valid_i,
    output logic read_data_ready_o,
    input wire logic [DATA_W-1:0] read_data_i,
    input wire logic [1:0] read_resp_i,
    input wire logic [ID_W-1:0] read_data_id_i,
    input wire logic read_last_i
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    arp_state_type state_q;
    arp_state_type state_d;
    arp_ar_type ar_q;
    logic ar_valid_q;
    logic [LEN_W:0] left_q;
    logic take_req;
    logic addr_done;
    logic beat_take;
    logic fifo_in_ready;
    logic [LEN_W:0] space_q;

    // bus edges only exist where the enable is high
    assign addr_done = bus_clock_enable_i && ar_valid_q
                       && read_addr_ready_i;
    assign beat_take = bus_clock_enable_i && read_data_valid_i
                       && read_data_ready_o;
    assign take_req = (state_q == ST_IDLE) && req_valid_i;
    assign req_ready_o = (state_q == ST_IDLE);
    assign busy_o = (state_q != ST_IDLE);
    assign state_o = state_q;

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (take_req) begin
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (addr_done) begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA: begin
                if (beat_take && (read_last_i || left_q == 1)) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // address channel
    // ------------------------------------------------------------
    // request captured once and held until the handshake completes
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ar_q <= '0;
            ar_q.burst <= BURST_INCR;
            ar_q.lock <= LOCK_NORMAL;
            ar_q.addr <= ADDR_RST;
            ar_q.len <= LEN_RST;
        end else if (take_req) begin
            ar_q.addr <= req_i.addr;
            ar_q.id <= req_i.id;
            ar_q.burst <= req_i.wrap ? BURST_WRAP : BURST_INCR;
            ar_q.len <= req_i.len;
            ar_q.lock <= LOCK_NORMAL;
            ar_q.size <= size_field(req_i.size);
            ar_q.cache <= req_i.cache;
            ar_q.prot <= req_i.prot;
            ar_q.user <= user_field(req_i.inner,
                                    req_i.shared);
        end
    end

    // valid only drops on an enabled edge, so the slow bus sees it stable
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ar_valid_q <= 1'b0;
        end else if (take_req) begin
            ar_valid_q <= 1'b1;
        end else if (addr_done) begin
            ar_valid_q <= 1'b0;
        end
    end

    assign read_addr_valid_o = ar_valid_q;
    assign read_addr_o = ar_q.addr;
    assign read_id_o = ar_q.id;
    assign read_burst_type_o = ar_q.burst;
    assign read_burst_length_o = ar_q.len;
    assign read_lock_type_o = ar_q.lock;
    assign read_transfer_size_o = ar_q.size;
    assign read_cache_type_o = ar_q.cache;
    assign read_prot_o = ar_q.prot;
    assign read_attr_sideband_o = ar_q.user;

    // ------------------------------------------------------------
    // data channel
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            left_q <= '0;
        end else if (take_req) begin
            left_q <= {1'b0, req_i.len} + 1'b1;
        end else if (beat_take && left_q != '0) begin
            left_q <= left_q - 1'b1;
        end
    end

    // ready must hold a whole bus period, so it follows the fifo's ready as sampled
    // on the enabled edge, gated also by the fifo's raw ready
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            space_q <= '0;
        end else if (bus_clock_enable_i) begin
            space_q <= {4'h0, fifo_in_ready};
        end
    end

    assign read_data_ready_o = (state_q == ST_DATA) && fifo_in_ready
                               && space_q[0];

    arp_fifo #(
        .WIDTH($bits(arp_beat_type)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(beat_take),
        .in_ready_o(fifo_in_ready),
        .in_data_i({read_data_i, read_resp_i, read_data_id_i,
                    read_last_i || left_q == 1}),
        .out_valid_o(beat_valid_o),
        .out_ready_i(beat_ready_i),
        .out_data_o(beat_o)
    );

endmodule // arp_read_port

// File: tb/arp_monitor.sv
// checker of the read port address channel
// bound to arp_read_port, sees only its ports
`timescale 1ns/1ns
module arp_monitor
    import arp_pkg::*;
(
    // watched ports
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic bus_clock_enable_i,
    input wire logic req_valid_i,
    input wire logic req_ready_o,
    input wire arp_req_type req_i,
    input wire logic read_addr_valid_o,
    input wire logic read_addr_ready_i,
    input wire logic [ADDR_W-1:0] read_addr_o,
    input wire logic [1:0] read_burst_type_o,
    input wire logic [LEN_W-1:0] read_burst_length_o,
    input wire logic [1:0] read_lock_type_o,
    input wire logic [1:0] read_transfer_size_o,
    input wire logic [3:0] read_cache_type_o,
    input wire logic [USER_W-1:0] read_attr_sideband_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    wire logic take = req_valid_i && req_ready_o;
    property p_burst;
        take |=> read_burst_type_o == ($past(req_i.wrap) ? 2'h2 : 2'h1);
    endproperty
    a_burst: assert property (p_burst)
        else $error("burst type");
    property p_len;
        take |=> read_addr_valid_o && read_burst_length_o == $past(req_i.len);
    endproperty
    a_len: assert property (p_len)
        else $error("burst length");
    property p_lock;
        read_addr_valid_o |-> read_lock_type_o == 2'h0;
    endproperty
    a_lock: assert property (p_lock)
        else $error("lock type");
    property p_size;
        take |=> read_transfer_size_o == ($past(req_i.size[2]) ? 2'h3
            : $past(req_i.size[1:0]));
    endproperty
    a_size: assert property (p_size)
        else $error("transfer size");
    property p_user;
        take |=> read_attr_sideband_o
            == {$past(req_i.inner), $past(req_i.shared)};
    endproperty
    a_user: assert property (p_user)
        else $error("sideband");
    property p_cache;
        take |=> read_cache_type_o == $past(req_i.cache);
    endproperty
    a_cache: assert property (p_cache)
        else $error("cache type");
    property p_hold;
        read_addr_valid_o && !(bus_clock_enable_i && read_addr_ready_i) |=>
            read_addr_valid_o && $stable(read_addr_o)
            && $stable(read_attr_sideband_o);
    endproperty
    a_hold: assert property (p_hold)
        else $error("request not held");
    property p_drop;
        $fell(read_addr_valid_o) |->
            $past(bus_clock_enable_i) && $past(read_addr_ready_i);
    endproperty
    a_drop: assert property (p_drop)
        else $error("valid dropped off a bus edge");
endmodule // arp_monitor

bind arp_read_port arp_monitor u_mon (.clock_i, .rst_i, .bus_clock_enable_i,
    .req_valid_i, .req_ready_o, .req_i, .read_addr_valid_o,
    .read_addr_ready_i, .read_addr_o, .read_burst_type_o,
    .read_burst_length_o, .read_lock_type_o, .read_transfer_size_o,
    .read_cache_type_o, .read_attr_sideband_o);

// File: tb/arp_slave_model.sv
// far-side model: takes read addresses, returns counted beats
// assumes the port samples its ready on enabled edges only
`timescale 1ns/1ns
module arp_slave_model
    import arp_pkg::*;
(
    // clock and pacing
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic bus_clock_enable_i,
    input wire logic slow_i,
    // address channel
    input wire logic addr_valid_i,
    output logic addr_ready_o,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [ID_W-1:0] id_i,
    input wire logic [LEN_W-1:0] len_i,
    // data channel
    output logic data_valid_o,
    input wire logic data_ready_i,
    output logic [DATA_W-1:0] data_o,
    output logic [1:0] resp_o,
    output logic [ID_W-1:0] id_o,
    output logic last_o
);
    logic [ADDR_W-1:0] addr_q;
    logic [4:0] left_q = 5'h00;
    logic [7:0] beat_q = 8'h00;
    logic tick_q = 1'h0;
    assign resp_o = 2'h0;
    // the bus moves only on enabled edges
    always @(posedge clock_i) begin
        logic [4:0] n;
        logic [7:0] b;
        logic h;
        n = left_q;
        b = beat_q;
        h = addr_valid_i && addr_ready_o;
        if (rst_i) begin
            n = 5'h00;
            addr_ready_o <= 1'h0;
            data_valid_o <= 1'h0;
            data_o <= '0;
            last_o <= 1'h0;
            id_o <= '0;
        end else if (bus_clock_enable_i) begin
            tick_q <= ~tick_q;
            if (h) begin
                n = 5'(len_i) + 5'h01;
                b = 8'h00;
                addr_q <= addr_i;
                id_o <= id_i;
            end
            // a beat counts only on valid and ready
            if (data_valid_o && data_ready_i) begin
                n = n - 5'h01;
                b = b + 8'h01;
            end
            addr_ready_o <= addr_valid_i && !h && n == 5'h00
                && (!slow_i || tick_q);
            if (data_valid_o && !data_ready_i) begin
                data_valid_o <= 1'h1;
            end else if (n != 5'h00 && !h && (!slow_i || tick_q)) begin
                data_valid_o <= 1'h1;
                data_o <= {addr_q, 24'h0, b};
                last_o <= n == 5'h01;
            end else begin
                // released lines must not keep showing the last beat
                data_valid_o <= 1'h0;
                data_o <= ~data_o;
                last_o <= 1'h0;
            end
        end
        left_q <= n;
        beat_q <= b;
    end
endmodule // arp_slave_model

// File: tb/tb_top.sv
// self-checking bench for the instruction read port
// far side is arp_slave_model; the checker is bound in
`timescale 1ns/1ns
module tb_top
    import arp_pkg::*;
;
    logic clock_i = 1'h0;
    logic rst_i = 1'h1;
    logic en = 1'h1;
    logic slow = 1'h0;
    logic req_valid = 1'h0;
    logic beat_ready = 1'h0;
    arp_req_type req = '0;
    arp_beat_type beat;
    logic req_ready, beat_valid, busy, av, ar, dv, dr, last;
    logic [1:0] bt, lk, sz, resp, st;
    logic [2:0] prot;
    logic [3:0] bl, ca;
    logic [USER_W-1:0] usr;
    logic [ID_W-1:0] aid, did;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    int n_fail = 0;
    int checks_done = 0;
    int ratio = 1;
    int ecnt = 0;
    int cyc = 0;
    arp_read_port DUT (.clock_i, .rst_i, .bus_clock_enable_i(en),
        .req_valid_i(req_valid), .req_ready_o(req_ready), .req_i(req),
        .beat_valid_o(beat_valid), .beat_ready_i(beat_ready), .beat_o(beat),
        .busy_o(busy), .state_o(st), .read_addr_valid_o(av),
        .read_addr_ready_i(ar), .read_addr_o(addr), .read_id_o(aid),
        .read_burst_type_o(bt), .read_burst_length_o(bl),
        .read_lock_type_o(lk), .read_transfer_size_o(sz),
        .read_cache_type_o(ca), .read_prot_o(prot), .read_attr_sideband_o(usr),
        .read_data_valid_i(dv), .read_data_ready_o(dr), .read_data_i(data),
        .read_resp_i(resp), .read_data_id_i(did), .read_last_i(last));
    arp_slave_model far (.clock_i, .rst_i, .bus_clock_enable_i(en),
        .slow_i(slow), .addr_valid_i(av), .addr_ready_o(ar), .addr_i(addr),
        .id_i(aid), .len_i(bl), .data_valid_o(dv), .data_ready_i(dr),
        .data_o(data), .resp_o(resp), .id_o(did), .last_o(last));
    always #10 clock_i = ~clock_i;
    // bus edge on every ratio-th clock
    always @(posedge clock_i) begin
        ecnt <= (ecnt + 1 >= ratio) ? 0 : ecnt + 1;
        en <= ecnt + 1 >= ratio;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic run(input arp_req_type r, input int stall);
        int n;
        @(posedge clock_i);
        req <= r;
        req_valid <= 1'h1;
        beat_ready <= stall == 0;
        @(negedge clock_i);
        check(req_ready, 1'h1);
        @(posedge clock_i);
        req_valid <= 1'h0;
        @(negedge clock_i);
        check({busy, req_ready, av}, 3'h5);
        check(st, ST_ADDR);
        check(aid, r.id);
        check(prot, r.prot);
        check(bt, r.wrap ? BURST_WRAP : BURST_INCR);
        check(bl, r.len);
        check(lk, LOCK_NORMAL);
        check(sz, (r.size > SIZE_64) ? 2'(SIZE_64) : r.size[1:0]);
        check(usr, {r.inner, r.shared});
        check(ca, r.cache);
        if (stall > 0) begin
            repeat (stall) @(negedge clock_i);
            check({dr, beat_valid}, 2'h1);
            @(posedge clock_i);
            beat_ready <= 1'h1;
        end
        n = 0;
        while (n <= int'(r.len)) begin
            @(negedge clock_i);
            if (beat_valid) begin
                check(beat.data, {r.addr, 24'h0, 8'(n)});
                check(beat.last, n == int'(r.len));
                check(beat.id, r.id);
                n++;
            end
        end
        @(negedge clock_i);
        check({busy, beat_valid}, 2'h0);
    endtask
    task automatic t_codes();
        logic [3:0] codes [6] = '{INNER_SO, INNER_DEV, INNER_NC, INNER_WT,
            INNER_WB_NA, INNER_WB_WA};
        arp_req_type r;
        for (int i = 0; i < 6; i++) begin
            r = '0;
            r.addr = 32'h1000_0000 + 32'(i * 64);
            r.len = 4'(i);
            r.size = 3'(i % 4);
            r.id = 6'(i + 1);
            r.prot = 3'(i);
            r.wrap = i[0] && i < 4;
            r.cache = 4'(i);
            r.inner = codes[i];
            r.shared = i[1];
            run(r, 0);
        end
        $display("t_codes done");
    endtask
    task automatic t_ratio();
        ratio = 3;
        slow = 1'h1;
        run('{addr: 32'h2000_0040, len: 4'h3, size: 3'h3, default: '0}, 0);
        // size code above the 64-bit code must come out clamped
        run('{addr: 32'h2000_0080, wrap: 1'h1, len: 4'h1, size: 3'h6,
            inner: 4'hF, default: '0}, 0);
        $display("t_ratio done");
    endtask
    task automatic t_full();
        ratio = 1;
        slow = 1'h0;
        run('{addr: 32'h3000_0000, len: 4'hF, shared: 1'h1, default: '0}, 40);
        $display("t_full done");
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        rst_i <= 1'h0;
        t_codes();
        t_ratio();
        t_full();
        give_verdict();
    end
endmodule // tb_top
